/* File: rtl/cmc_defines.vh */
// Purpose: Shared constants for the CAN mode control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Included by the bit counter and mode control design files of the block
`ifndef CMC_DEFINES_VH
`define CMC_DEFINES_VH

// Register byte addresses
`define CMC_ADDR_CTL0      8'h00
`define CMC_ADDR_CTL1      8'h04
`define CMC_ADDR_TIMING_A  8'h08
`define CMC_ADDR_TIMING_B  8'h0c
`define CMC_ADDR_STATUS    8'h10
`define CMC_ADDR_TSTAMP    8'h14
`define CMC_ADDR_RXFLAG    8'h18
`define CMC_ADDR_TXFLAG    8'h1c
`define CMC_ADDR_CFG_MASK  8'he0

// Mode control bit positions
`define CMC_B_RECEIVED_FRAME_FLAG   7
`define CMC_B_RECEIVER_ACTIVE   6
`define CMC_B_SWAIT   5
`define CMC_B_SYNC    4
`define CMC_B_TIME    3
`define CMC_B_WAKE    2
`define CMC_B_SLEEP_REQUEST   1
`define CMC_B_INIT_REQUEST  0

// Status register bit positions
`define CMC_S_INIT_ACKNOWLEDGE  0
`define CMC_S_SLEEP_ACKNOWLEDGE   1
`define CMC_S_WAKE_INTERRUPT_FLAG   2
`define CMC_S_BUSOFF  3
`define CMC_S_CLKGATE 4

// Reset values
`define CMC_CTL0_RST  8'h00
`define CMC_BYTE_RST  8'h00

// Synchronisation counts
`define CMC_IDLE_BITS    4'hb
`define CMC_BUSOFF_SEQS  8'h80

`endif

/* File: rtl/cmc_bit_counter.v */
// Purpose: Counts consecutive recessive bits and completed idle runs
// Assumes: bit_tick pulses once per bit time
// Notes:   Cleared by clr; done stays set from reaching the target until clr
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"
module cmc_bit_counter #(
  parameter RUN_W = 4,
  parameter SEQ_W = 8
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             clr,
  input  wire             bit_tick,
  input  wire             rx_bit,
  input  wire             need_busoff,
  // Result
  output reg              done_ff
);
  reg  [RUN_W-1:0] run_ff;
  reg  [SEQ_W-1:0] seq_ff;
  wire             run_full;
  wire [SEQ_W-1:0] seq_target;

  assign run_full   = (run_ff == `CMC_IDLE_BITS - 4'h1) & rx_bit;
  assign seq_target = need_busoff ? `CMC_BUSOFF_SEQS : 8'h01;

  // Recessive runs of 11 bits, 128 of them when bus-off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff  <= 4'h0;
      seq_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else if (clr) begin
      run_ff  <= 4'h0;
      seq_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else if (bit_tick && !done_ff) begin
      if (!rx_bit) begin
        run_ff <= 4'h0;
      end else if (run_full) begin
        run_ff <= 4'h0;
        seq_ff <= seq_ff + 8'h01;
        if (seq_ff + 8'h01 == seq_target) begin
          done_ff <= 1'b1;
        end
      end else begin
        run_ff <= run_ff + 4'h1;
      end
    end
  end
endmodule // cmc_bit_counter
`default_nettype wire

/* File: rtl/cmc_cfg_mem.v */
// Purpose: Small store for the filter acceptance and mask bytes
// Assumes: One byte per entry, registered read data
// Notes:   Writes are gated by the caller
`timescale 1ns/1ps
`default_nettype none
module cmc_cfg_mem #(
  parameter AW = 4,
  parameter DW = 8
) (
  // Clock
  input  wire          pclk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_ff
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: contents are only meaningful once software has set them
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // cmc_cfg_mem
`default_nettype wire

/* File: rtl/cmc_mode_ctrl.v */
// Purpose: Mode control register of a CAN controller with its handshakes
// Assumes: APB slave, one clock; protocol engine events arrive as inputs
// Notes:   Two-cycle APB answer on every access; unmapped reads give zero
//
// How it works
// - Init mode holds register reset except three
// - Register writable again after init exit
// - Writes only outside init except init request; some bits fixed
// - Frame flag set by hardware, write-one clears
// - Receiver active bit mirrors receiver front end in run state only
// - Stop-in-wait gates bus interface clock
// - Synchronized bit is hardware status only
// - Timer runs at bit rate, cleared off
// - Acknowledge writes timestamp to active buffer
// - Timer enable forced low in init
// - Wake enable lets bus traffic end sleep
// - Sleep entered only when bus idle
// - Sleep request refused while wake flag set
// - Sleep ends by CPU or wake detect
// - Init request aborts traffic, drops sync
// - Init entry resets receive and transmit flag registers
// - Config registers writable only in init
// - Error counters kept across init mode
// - Resync after 11 recessive bits, 128 bus-off
// - Sleep request not clearable before sleep acknowledged
// - Init request not clearable before init acknowledged
// - Init request forces transmit pin recessive
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"
module cmc_mode_ctrl #(
  parameter RUN_W = 4,
  parameter SEQ_W = 8,
  parameter TS_W  = 16
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // Protocol engine status
  input  wire        bit_tick,
  input  wire        rx_bit,
  input  wire        rx_busy,
  input  wire        frame_valid,
  input  wire        frame_acked,
  input  wire        tx_buffers_empty,
  input  wire        bus_off,
  input  wire        wake_detect,
  input  wire        wait_mode,
  input  wire        engine_tx_bit,
  // Protocol engine control
  output reg         bus_transmit_pin_ff,
  output reg         abort_traffic_ff,
  output reg         stamp_write_ff,
  output reg  [15:0] stamp_value_ff,
  output reg         bus_clk_gate_ff,
  output reg  [7:0]  rx_flags_ff,
  output reg  [7:0]  tx_flags_ff,
  output reg  [7:0]  mode_control_reg_b_ff,
  output reg  [7:0]  bit_timing_reg_a_ff,
  output reg  [7:0]  bit_timing_reg_b_ff
);
  localparam ST_RUN   = 2'b00;
  localparam ST_SLEEP = 2'b01;
  localparam ST_INIT  = 2'b10;
  localparam ST_SYNC  = 2'b11;

  reg  [1:0]      state_ff;
  reg  [1:0]      nxt_state;
  reg  [7:0]      ctl0_ff;
  reg  [7:0]      nxt_ctl0;
  reg             init_ack_ff;
  reg             sleep_ack_ff;
  reg             wake_flag_ff;
  reg             sync_ff;
  reg  [TS_W-1:0] timer_ff;
  reg             access_ff;
  wire            setup;
  wire            wr_acc;
  wire            in_init;
  wire            out_of_init;
  wire            resync_done;
  wire [7:0]      mem_rd;
  wire            mem_sel;
  wire            cfg_wr_ok;

  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  assign setup       = psel & ~penable;
  assign wr_acc      = psel & penable & pwrite & ~pready_ff;
  assign in_init     = ctl0_ff[`CMC_B_INIT_REQUEST] & init_ack_ff;
  assign out_of_init = ~ctl0_ff[`CMC_B_INIT_REQUEST] & ~init_ack_ff;
  assign mem_sel     = (paddr[7:6] == `CMC_ADDR_CFG_MASK >> 6) & (paddr[1:0] == 2'b00);
  assign cfg_wr_ok   = in_init;

  cmc_bit_counter #(
    .RUN_W(RUN_W),
    .SEQ_W(SEQ_W)
  ) u_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .clr        (state_ff != ST_SYNC),
    .bit_tick   (bit_tick),
    .rx_bit     (rx_bit),
    .need_busoff(bus_off),
    .done_ff    (resync_done)
  );

  // Acceptance bytes at 0xc0..0xfc: eight filters then eight masks
  cmc_cfg_mem #(
    .AW(4),
    .DW(8)
  ) u_cfg (
    .pclk      (pclk),
    .wr_en     (wr_acc & mem_sel & cfg_wr_ok),
    .wr_addr   (paddr[5:2]),
    .wr_data   (pwdata[7:0]),
    .rd_addr   (paddr[5:2]),
    .rd_data_ff(mem_rd)
  );

  // Mode state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (ctl0_ff[`CMC_B_INIT_REQUEST]) begin
          nxt_state = ST_INIT;
        end else if (ctl0_ff[`CMC_B_SLEEP_REQUEST] && !rx_busy && tx_buffers_empty) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ctl0_ff[`CMC_B_INIT_REQUEST]) begin
          nxt_state = ST_INIT;
        end else if (!ctl0_ff[`CMC_B_SLEEP_REQUEST]) begin
          nxt_state = ST_SYNC;
        end
      end
      ST_INIT: begin
        if (!ctl0_ff[`CMC_B_INIT_REQUEST]) begin
          nxt_state = ST_SYNC;
        end
      end
      default: begin
        if (ctl0_ff[`CMC_B_INIT_REQUEST]) begin
          nxt_state = ST_INIT;
        end else if (resync_done) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  // Next control register value
  always @* begin
    nxt_ctl0 = ctl0_ff;
    if (wr_acc && is_addr(paddr, `CMC_ADDR_CTL0)) begin
      if (out_of_init) begin
        // Wait gate, timer, wake are plain software bits
        nxt_ctl0[`CMC_B_SWAIT] = pwdata[`CMC_B_SWAIT];
        nxt_ctl0[`CMC_B_TIME]  = pwdata[`CMC_B_TIME];
        nxt_ctl0[`CMC_B_WAKE]  = pwdata[`CMC_B_WAKE];
        if (pwdata[`CMC_B_RECEIVED_FRAME_FLAG]) begin
          nxt_ctl0[`CMC_B_RECEIVED_FRAME_FLAG] = 1'b0;
        end
        if (pwdata[`CMC_B_SLEEP_REQUEST] && !wake_flag_ff) begin
          nxt_ctl0[`CMC_B_SLEEP_REQUEST] = 1'b1;
        end else if (!pwdata[`CMC_B_SLEEP_REQUEST] && sleep_ack_ff) begin
          nxt_ctl0[`CMC_B_SLEEP_REQUEST] = 1'b0;
        end
      end
      if (pwdata[`CMC_B_INIT_REQUEST]) begin
        nxt_ctl0[`CMC_B_INIT_REQUEST] = 1'b1;
      end else if (in_init) begin
        nxt_ctl0[`CMC_B_INIT_REQUEST] = 1'b0;
      end
    end
    // Hardware sets win over a simultaneous clear
    if (frame_valid) begin
      nxt_ctl0[`CMC_B_RECEIVED_FRAME_FLAG] = 1'b1;
    end
    if (state_ff == ST_SLEEP && ctl0_ff[`CMC_B_WAKE] && wake_detect) begin
      nxt_ctl0[`CMC_B_SLEEP_REQUEST] = 1'b0;
    end
    nxt_ctl0[`CMC_B_RECEIVER_ACTIVE] = rx_busy & (state_ff == ST_RUN);
    nxt_ctl0[`CMC_B_SYNC]  = sync_ff;
    if (in_init) begin
      // Hold reset state except wake, sleep and init request
      nxt_ctl0 = (`CMC_CTL0_RST & ~8'h07) | (nxt_ctl0 & 8'h07);
    end
  end

  // Control and handshake state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_SYNC;
      ctl0_ff      <= `CMC_CTL0_RST;
      init_ack_ff  <= 1'b0;
      sleep_ack_ff <= 1'b0;
      wake_flag_ff <= 1'b0;
      sync_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      ctl0_ff      <= nxt_ctl0;
      init_ack_ff  <= (nxt_state == ST_INIT);
      sleep_ack_ff <= (nxt_state == ST_SLEEP) & nxt_ctl0[`CMC_B_SLEEP_REQUEST];
      sync_ff      <= (nxt_state == ST_RUN);
      if (state_ff == ST_SLEEP && ctl0_ff[`CMC_B_WAKE] && wake_detect) begin
        wake_flag_ff <= 1'b1;
      end else if (wr_acc && is_addr(paddr, `CMC_ADDR_RXFLAG) && out_of_init &&
                   pwdata[`CMC_S_WAKE_INTERRUPT_FLAG]) begin
        wake_flag_ff <= 1'b0;
      end
    end
  end

  // Timestamp timer and capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff       <= {TS_W{1'b0}};
      stamp_write_ff <= 1'b0;
      stamp_value_ff <= 16'h0000;
    end else begin
      stamp_write_ff <= ctl0_ff[`CMC_B_TIME] & frame_acked;
      if (ctl0_ff[`CMC_B_TIME] && frame_acked) begin
        stamp_value_ff <= timer_ff[15:0];
      end
      if (!ctl0_ff[`CMC_B_TIME]) begin
        timer_ff <= {TS_W{1'b0}};
      end else if (bit_tick) begin
        timer_ff <= timer_ff + {{(TS_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Engine-facing outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_transmit_pin_ff <= 1'b1;
      abort_traffic_ff    <= 1'b0;
      bus_clk_gate_ff     <= 1'b0;
    end else begin
      // Recessive at once, before the handshake completes
      bus_transmit_pin_ff <= engine_tx_bit | nxt_ctl0[`CMC_B_INIT_REQUEST] |
                             (wait_mode & ctl0_ff[`CMC_B_SWAIT]);
      abort_traffic_ff    <= nxt_ctl0[`CMC_B_INIT_REQUEST];
      bus_clk_gate_ff     <= wait_mode & ctl0_ff[`CMC_B_SWAIT];
    end
  end

  // Side registers; error counters live in the engine and are untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flags_ff           <= `CMC_BYTE_RST;
      tx_flags_ff           <= `CMC_BYTE_RST;
      mode_control_reg_b_ff <= `CMC_BYTE_RST;
      bit_timing_reg_a_ff   <= `CMC_BYTE_RST;
      bit_timing_reg_b_ff   <= `CMC_BYTE_RST;
    end else begin
      if (in_init) begin
        rx_flags_ff <= `CMC_BYTE_RST;
        tx_flags_ff <= `CMC_BYTE_RST;
      end else if (wr_acc && out_of_init) begin
        if (is_addr(paddr, `CMC_ADDR_RXFLAG)) begin
          rx_flags_ff <= pwdata[7:0];
        end else if (is_addr(paddr, `CMC_ADDR_TXFLAG)) begin
          tx_flags_ff <= pwdata[7:0];
        end
      end
      if (wr_acc && cfg_wr_ok) begin
        if (is_addr(paddr, `CMC_ADDR_CTL1)) begin
          mode_control_reg_b_ff <= pwdata[7:0];
        end else if (is_addr(paddr, `CMC_ADDR_TIMING_A)) begin
          bit_timing_reg_a_ff <= pwdata[7:0];
        end else if (is_addr(paddr, `CMC_ADDR_TIMING_B)) begin
          bit_timing_reg_b_ff <= pwdata[7:0];
        end
      end
    end
  end

  // APB: ready one cycle into the access phase so memory data is valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_ff  <= 1'b0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      access_ff  <= setup;
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= 1'b0;
      if (psel && penable && !pready_ff && !pwrite) begin
        if (is_addr(paddr, `CMC_ADDR_CTL0)) begin
          prdata_ff <= {24'h000000, ctl0_ff};
        end else if (is_addr(paddr, `CMC_ADDR_CTL1)) begin
          prdata_ff <= {24'h000000, mode_control_reg_b_ff};
        end else if (is_addr(paddr, `CMC_ADDR_TIMING_A)) begin
          prdata_ff <= {24'h000000, bit_timing_reg_a_ff};
        end else if (is_addr(paddr, `CMC_ADDR_TIMING_B)) begin
          prdata_ff <= {24'h000000, bit_timing_reg_b_ff};
        end else if (is_addr(paddr, `CMC_ADDR_STATUS)) begin
          prdata_ff <= {27'h0000000, bus_clk_gate_ff, bus_off, wake_flag_ff,
                        sleep_ack_ff, init_ack_ff};
        end else if (is_addr(paddr, `CMC_ADDR_TSTAMP)) begin
          prdata_ff <= {16'h0000, timer_ff[15:0]};
        end else if (is_addr(paddr, `CMC_ADDR_RXFLAG)) begin
          prdata_ff <= {24'h000000, rx_flags_ff};
        end else if (is_addr(paddr, `CMC_ADDR_TXFLAG)) begin
          prdata_ff <= {24'h000000, tx_flags_ff};
        end else if (mem_sel && access_ff) begin
          prdata_ff <= {24'h000000, mem_rd};
        end else begin
          prdata_ff <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // cmc_mode_ctrl
`default_nettype wire

/* File: tb/cmc_mode_chk.sv */
// Purpose: Port checks for the CAN mode control block
// Assumes: Single pclk domain, presetn active low
// Notes:   Bound onto every instance of the block
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"
module cmc_mode_chk #(
  parameter RUN_W = 4,
  parameter SEQ_W = 8,
  parameter TS_W  = 16
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // Engine side
  input wire logic        frame_acked,
  input wire logic        wait_mode,
  input wire logic        bus_transmit_pin_ff,
  input wire logic        abort_traffic_ff,
  input wire logic        stamp_write_ff,
  input wire logic        bus_clk_gate_ff,
  input wire logic [7:0]  mode_control_reg_b_ff,
  input wire logic [7:0]  bit_timing_reg_a_ff,
  input wire logic [7:0]  bit_timing_reg_b_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && !pready_ff;

  property p_ready_pulse; pready_ff |=> !pready_ff; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_ans; acc |=> pready_ff; endproperty
  a_ready_ans: assert property (p_ready_ans) else $error("access not answered");
  property p_no_err; !pslverr_ff; endproperty
  a_no_err: assert property (p_no_err) else $error("slave error raised");
  property p_init_set; acc && pwrite && paddr == `CMC_ADDR_CTL0 && pwdata[0] |=> abort_traffic_ff;
  endproperty
  a_init_set: assert property (p_init_set) else $error("init request did not abort");
  property p_init_hold;
    abort_traffic_ff && !(acc && pwrite && paddr == `CMC_ADDR_CTL0 && !pwdata[0])
      |=> abort_traffic_ff;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init request lost");
  property p_pin; abort_traffic_ff |-> bus_transmit_pin_ff; endproperty
  a_pin: assert property (p_pin) else $error("pin not recessive in init");
  property p_gate; !wait_mode |=> !bus_clk_gate_ff; endproperty
  a_gate: assert property (p_gate) else $error("clock gated outside wait");
  property p_stamp_init; abort_traffic_ff && $past(abort_traffic_ff, 3) |-> !stamp_write_ff;
  endproperty
  a_stamp_init: assert property (p_stamp_init) else $error("stamp while in init");
  property p_stamp_cause; stamp_write_ff |-> $past(frame_acked); endproperty
  a_stamp_cause: assert property (p_stamp_cause) else $error("stamp without ack");
  // Config only moves when a write lands in init, so it stays put otherwise
  property p_cfg_lock;
    !abort_traffic_ff |=> $stable(mode_control_reg_b_ff) && $stable(bit_timing_reg_a_ff)
      && $stable(bit_timing_reg_b_ff);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config changed outside init");
endmodule // cmc_mode_chk
bind cmc_mode_ctrl cmc_mode_chk #(.RUN_W(RUN_W), .SEQ_W(SEQ_W), .TS_W(TS_W)) u_cmc_mode_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .frame_acked(frame_acked), .wait_mode(wait_mode), .bus_transmit_pin_ff(bus_transmit_pin_ff),
  .abort_traffic_ff(abort_traffic_ff), .stamp_write_ff(stamp_write_ff),
  .bus_clk_gate_ff(bus_clk_gate_ff), .mode_control_reg_b_ff(mode_control_reg_b_ff),
  .bit_timing_reg_a_ff(bit_timing_reg_a_ff), .bit_timing_reg_b_ff(bit_timing_reg_b_ff));
`default_nettype wire

/* File: tb/cmc_engine_model.sv */
// Purpose: Far-side protocol engine and bus model
// Assumes: One bit time every four pclk cycles
// Notes:   Bench commands pick traffic; an idle bus reads recessive
`timescale 1ns/1ps
`default_nettype none
module cmc_engine_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Commands
  input  wire logic busy_cmd,
  input  wire logic frame_cmd,
  input  wire logic wake_cmd,
  input  wire logic boff_cmd,
  // Engine side
  output logic      bit_tick,
  output logic      rx_bit,
  output logic      rx_busy,
  output logic      frame_valid,
  output logic      frame_acked,
  output logic      tx_buffers_empty,
  output logic      bus_off,
  output logic      wake_detect,
  output logic      engine_tx_bit
);
  logic [1:0] div_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_ff <= 2'h0;
    else
      div_ff <= div_ff + 2'h1;
  end
  assign bit_tick = (div_ff == 2'h3);
  // Traffic pulls the bus dominant so no idle run can be counted
  assign rx_bit = !(busy_cmd | wake_cmd);
  assign rx_busy = busy_cmd;
  assign frame_valid = frame_cmd;
  assign frame_acked = frame_cmd;
  // No queued transmit here, so sleep waits on reception only
  assign tx_buffers_empty = 1'b1;
  assign bus_off = boff_cmd;
  assign wake_detect = wake_cmd;
  // Dominant, so a forced recessive pin is visible
  assign engine_tx_bit = 1'b0;
endmodule // cmc_engine_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Register-level test of the CAN mode control block
// Assumes: APB master tasks; engine model on the far side
// Notes:   Bus-off resync runs the full 128 idle runs
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata_ff;
  logic busy_cmd = 1'b0, frame_cmd = 1'b0, wake_cmd = 1'b0, boff_cmd = 1'b0, wait_mode = 1'b0;
  logic bit_tick, rx_bit, rx_busy, frame_valid, frame_acked, tx_buffers_empty, bus_off;
  logic wake_detect, engine_tx_bit, pready_ff, pslverr_ff, bus_transmit_pin_ff;
  logic abort_traffic_ff, stamp_write_ff, bus_clk_gate_ff, seen_stamp = 1'b0;
  logic [15:0] stamp_value_ff;
  logic [7:0] rx_flags_ff, tx_flags_ff, mode_control_reg_b_ff;
  logic [7:0] bit_timing_reg_a_ff, bit_timing_reg_b_ff;
  int errors = 0, comparisons = 0, cycles = 0;
  always #10 pclk = ~pclk;

  cmc_engine_model u_cmc_engine_model (.pclk(pclk), .presetn(presetn), .busy_cmd(busy_cmd),
    .frame_cmd(frame_cmd), .wake_cmd(wake_cmd), .boff_cmd(boff_cmd), .bit_tick(bit_tick),
    .rx_bit(rx_bit), .rx_busy(rx_busy), .frame_valid(frame_valid), .frame_acked(frame_acked),
    .tx_buffers_empty(tx_buffers_empty), .bus_off(bus_off), .wake_detect(wake_detect),
    .engine_tx_bit(engine_tx_bit));
  cmc_mode_ctrl #(.RUN_W(4), .SEQ_W(8), .TS_W(16)) u_cmc_mode_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .bit_tick(bit_tick), .rx_bit(rx_bit), .rx_busy(rx_busy), .frame_valid(frame_valid),
    .frame_acked(frame_acked), .tx_buffers_empty(tx_buffers_empty), .bus_off(bus_off),
    .wake_detect(wake_detect), .wait_mode(wait_mode), .engine_tx_bit(engine_tx_bit),
    .bus_transmit_pin_ff(bus_transmit_pin_ff), .abort_traffic_ff(abort_traffic_ff),
    .stamp_write_ff(stamp_write_ff), .stamp_value_ff(stamp_value_ff),
    .bus_clk_gate_ff(bus_clk_gate_ff), .rx_flags_ff(rx_flags_ff), .tx_flags_ff(tx_flags_ff),
    .mode_control_reg_b_ff(mode_control_reg_b_ff), .bit_timing_reg_a_ff(bit_timing_reg_a_ff),
    .bit_timing_reg_b_ff(bit_timing_reg_b_ff));

  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) @(posedge pclk);
    q = prdata_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 8'h00);
    chk($sformatf("reg_%h", a), q & m, e);
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Hang guard well above the ~7000 cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (stamp_write_ff === 1'b1)
      seen_stamp <= 1'b1;
    if (cycles == 12000) begin
      errors++;
      results();
    end
  end

  initial begin
    idle(12);
    presetn <= 1'b1;
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h00);
    idle(60);
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h10);
    wr(`CMC_ADDR_CTL0, 8'hec);
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h3c);
    rd(8'h20, 32'hff, 32'h00);
    wait_mode <= 1'b1;
    idle(3);
    chk("clk_gate", bus_clk_gate_ff, 32'h1);
    wait_mode <= 1'b0;
    frame_cmd <= 1'b1;
    idle(1);
    frame_cmd <= 1'b0;
    rd(`CMC_ADDR_CTL0, 32'h80, 32'h80);
    wr(`CMC_ADDR_CTL0, 8'h2c);
    rd(`CMC_ADDR_CTL0, 32'h80, 32'h80);
    wr(`CMC_ADDR_CTL0, 8'hac);
    rd(`CMC_ADDR_CTL0, 32'h80, 32'h00);
    chk("stamp_write", seen_stamp, 32'h1);
    busy_cmd <= 1'b1;
    idle(2);
    rd(`CMC_ADDR_CTL0, 32'h40, 32'h40);
    wr(`CMC_ADDR_CTL0, 8'h2e);
    rd(`CMC_ADDR_STATUS, 32'h02, 32'h00);
    wr(`CMC_ADDR_CTL0, 8'h2c);
    rd(`CMC_ADDR_CTL0, 32'h02, 32'h02);
    busy_cmd <= 1'b0;
    idle(2);
    rd(`CMC_ADDR_STATUS, 32'h02, 32'h02);
    wake_cmd <= 1'b1;
    idle(8);
    wake_cmd <= 1'b0;
    rd(`CMC_ADDR_CTL0, 32'h02, 32'h00);
    rd(`CMC_ADDR_STATUS, 32'h04, 32'h04);
    wr(`CMC_ADDR_CTL0, 8'h2e);
    rd(`CMC_ADDR_CTL0, 32'h02, 32'h00);
    wr(`CMC_ADDR_RXFLAG, 8'h04);
    rd(`CMC_ADDR_STATUS, 32'h04, 32'h00);
    // Sleep exit resyncs first; sleep is only taken from the running state
    idle(60);
    wr(`CMC_ADDR_CTL0, 8'h2e);
    rd(`CMC_ADDR_STATUS, 32'h02, 32'h02);
    wr(`CMC_ADDR_CTL0, 8'h2c);
    rd(`CMC_ADDR_STATUS, 32'h02, 32'h00);
    wr(`CMC_ADDR_CTL1, 8'h5a);
    rd(`CMC_ADDR_CTL1, 32'hff, 32'h00);
    wr(`CMC_ADDR_CTL0, 8'h01);
    rd(`CMC_ADDR_STATUS, 32'h01, 32'h01);
    chk("tx_pin", bus_transmit_pin_ff, 32'h1);
    chk("rx_flags", rx_flags_ff, 32'h0);
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h01);
    rd(`CMC_ADDR_TSTAMP, 32'hffff, 32'h0);
    wr(`CMC_ADDR_CTL0, 8'h2d);
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h01);
    wr(`CMC_ADDR_CTL1, 8'h5a);
    rd(`CMC_ADDR_CTL1, 32'hff, 32'h5a);
    wr(8'he4, 8'h3c);
    rd(8'he4, 32'hff, 32'h3c);
    boff_cmd <= 1'b1;
    wr(`CMC_ADDR_CTL0, 8'h00);
    rd(`CMC_ADDR_STATUS, 32'h01, 32'h00);
    wr(`CMC_ADDR_CTL0, 8'h04);
    rd(`CMC_ADDR_CTL0, 32'hff, 32'h04);
    idle(200);
    rd(`CMC_ADDR_CTL0, 32'h10, 32'h00);
    idle(6000);
    rd(`CMC_ADDR_CTL0, 32'h10, 32'h10);
    results();
  end
endmodule // tb
`default_nettype wire
